// >>> verilog/pot_host_cfg.svh
// constants for the two-wire potentiometer host controller
// assumes a 125 MHz system clock and a pulled-up open-drain bus
`ifndef POT_HOST_CFG_SVH
`define POT_HOST_CFG_SVH

// ------------------------------------------------------------
// device address and timing
// ------------------------------------------------------------
`define POT_ADDR_HIGH 5'h0b
`define CLK_PERIOD_NS 8
`define QTR_NS 2500
`define QTR_CYC ((`QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ------------------------------------------------------------
// register word indexes
// ------------------------------------------------------------
`define REG_CMD 3'h0
`define REG_ADDR_SEL 3'h1
`define REG_INSTR 3'h2
`define REG_WDATA 3'h3
`define REG_RDATA 3'h4
`define REG_STATUS 3'h5

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_CNT_LSB 4
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_NACK_BIT 2
`define INSTR_RST 8'h00
`define WDATA_RST 8'h80
`define ADDR_SEL_RST 2'h0

`endif

// >>> verilog/pot_host_pkg.sv
// types shared by the potentiometer host controller
// assumes the constants header is included by the design file
package pot_host_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} state_t;
  typedef enum logic [1:0] {BK_ADDR, BK_INSTR, BK_WDATA, BK_RDATA} kind_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_SWITCH, OP_NONE} op_t;

endpackage

// >>> verilog/pot_host.sv
// two-wire bus master that programs and reads back a digital potentiometer
// assumes an avalon-mm master for software, pull-ups on scl and sda
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pot_host_cfg.svh"

module pot_host (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_scl_i,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe
);
  import pot_host_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic waitreq_reg;
  logic [31:0] readdata_reg;
  logic [1:0] addr_sel_reg;
  logic [7:0] instr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic done_reg;
  logic nack_reg;
  logic scl_meta_reg, scl_sync_reg;
  logic sda_meta_reg, sda_sync_reg;
  logic scl_oe_reg, sda_oe_reg, pin_low_reg;
  state_t state_reg;
  kind_t kind_reg;
  op_t op_reg;
  logic rw_reg;
  logic [3:0] rem_reg;
  logic [3:0] bit_reg;
  logic [1:0] qtr_reg;
  logic [8:0] tick_reg;
  logic [7:0] shift_reg;
  logic bad_ack_reg;
  logic bus_take, bus_wr, cmd_go, adv, last_q;
  logic set_done, set_nack;
  logic [31:0] rd_mux;
  logic [7:0] addr_w_byte, addr_r_byte;

  // ------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // ------------------------------------------------------------
  assign bus_take = (i_avs_read | i_avs_write) & ~waitreq_reg;
  assign bus_wr = bus_take & i_avs_write & i_avs_byteenable[0];
  assign cmd_go = bus_wr & (i_avs_address == `REG_CMD) &
                  (state_reg == ST_IDLE);

  always_comb begin
    rd_mux = 32'h0;
    unique case (i_avs_address)
      `REG_ADDR_SEL: rd_mux[1:0] = addr_sel_reg;
      `REG_INSTR: rd_mux[7:0] = instr_reg;
      `REG_WDATA: rd_mux[7:0] = wdata_reg;
      `REG_RDATA: rd_mux[7:0] = rdata_reg;
      `REG_STATUS: begin
        rd_mux[`ST_BUSY_BIT] = (state_reg != ST_IDLE);
        rd_mux[`ST_DONE_BIT] = done_reg;
        rd_mux[`ST_NACK_BIT] = nack_reg;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      waitreq_reg <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      waitreq_reg <= ~((i_avs_read | i_avs_write) & waitreq_reg);
      if (i_avs_read & waitreq_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // settings may change mid-transfer; each byte takes them at its load
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      addr_sel_reg <= `ADDR_SEL_RST;
      instr_reg <= `INSTR_RST;
      wdata_reg <= `WDATA_RST;
    end else if (bus_wr) begin
      unique case (i_avs_address)
        `REG_ADDR_SEL: addr_sel_reg <= i_avs_writedata[1:0];
        `REG_INSTR: instr_reg <= {i_avs_writedata[7:3], 3'h0};
        `REG_WDATA: wdata_reg <= i_avs_writedata[7:0];
        default: addr_sel_reg <= addr_sel_reg;
      endcase
    end
  end

  // set wins over a write-one clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      done_reg <= set_done | (done_reg & ~(bus_wr &
        (i_avs_address == `REG_STATUS) & i_avs_writedata[`ST_DONE_BIT]));
      nack_reg <= set_nack | (nack_reg & ~(bus_wr &
        (i_avs_address == `REG_STATUS) & i_avs_writedata[`ST_NACK_BIT]));
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      scl_meta_reg <= i_scl_i;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= i_sda_i;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // quarter-bit timing
  // ------------------------------------------------------------
  // a stretched scl holds the high quarter until the line is seen high
  assign last_q = (tick_reg == 9'h0);
  assign adv = last_q & ~((qtr_reg == 2'h1) & ~scl_sync_reg);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tick_reg <= 9'(`QTR_CYC - 1);
    end else if (state_reg == ST_IDLE || adv) begin
      tick_reg <= 9'(`QTR_CYC - 1);
    end else if (!last_q) begin
      tick_reg <= tick_reg - 9'h1;
    end
  end

  // ------------------------------------------------------------
  // byte sequencer
  // ------------------------------------------------------------
  // fixed high address bits
  assign addr_w_byte = {`POT_ADDR_HIGH, addr_sel_reg, 1'b0};
  assign addr_r_byte = {`POT_ADDR_HIGH, addr_sel_reg, 1'b1};
  assign set_done = (state_reg == ST_STOP) & adv & (qtr_reg == 2'h3);
  assign set_nack = (state_reg == ST_BIT) & adv & (qtr_reg == 2'h3) &
                    (bit_reg == 4'h8) & (kind_reg != BK_RDATA) &
                    bad_ack_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= ST_IDLE;
      kind_reg <= BK_ADDR;
      op_reg <= OP_WRITE;
      rw_reg <= 1'b0;
      rem_reg <= 4'h0;
      bit_reg <= 4'h0;
      qtr_reg <= 2'h0;
      shift_reg <= 8'h0;
      bad_ack_reg <= 1'b0;
      rdata_reg <= 8'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          qtr_reg <= 2'h0;
          if (cmd_go) begin
            op_reg <= op_t'(i_avs_writedata[`CMD_OP_LSB +: 2]);
            rem_reg <= i_avs_writedata[`CMD_CNT_LSB +: 4];
            rw_reg <= (i_avs_writedata[`CMD_OP_LSB +: 2] == 2'(OP_READ));
            kind_reg <= BK_ADDR;
            shift_reg <= (i_avs_writedata[`CMD_OP_LSB +: 2] ==
                          2'(OP_READ)) ? addr_r_byte : addr_w_byte;
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (adv) begin
            qtr_reg <= qtr_reg + 2'h1;
            if (qtr_reg == 2'h3) begin
              bit_reg <= 4'h0;
              state_reg <= ST_BIT;
            end
          end
        end
        ST_BIT: begin
          if (adv) begin
            qtr_reg <= qtr_reg + 2'h1;
            if (qtr_reg == 2'h2) begin
              if (bit_reg == 4'h8) begin
                bad_ack_reg <= sda_sync_reg;
              end else if (kind_reg == BK_RDATA) begin
                shift_reg <= {shift_reg[6:0], sda_sync_reg};
              end
            end
            if (qtr_reg == 2'h3) begin
              bit_reg <= bit_reg + 4'h1;
              if (kind_reg != BK_RDATA && bit_reg != 4'h8) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
              if (bit_reg == 4'h8) begin
                bit_reg <= 4'h0;
                unique case (kind_reg)
                  BK_ADDR: begin
                    if (bad_ack_reg) begin
                      state_reg <= ST_STOP;
                    end else if (rw_reg) begin
                      kind_reg <= BK_RDATA;
                    end else begin
                      kind_reg <= BK_INSTR;
                      shift_reg <= instr_reg;
                    end
                  end
                  BK_INSTR: begin
                    if (bad_ack_reg) begin
                      state_reg <= ST_STOP;
                    end else if (op_reg == OP_SWITCH) begin
                      rw_reg <= 1'b1;
                      kind_reg <= BK_ADDR;
                      shift_reg <= addr_r_byte;
                      state_reg <= ST_START;
                    end else if (rem_reg != 4'h0) begin
                      kind_reg <= BK_WDATA;
                      shift_reg <= wdata_reg;
                    end else begin
                      state_reg <= ST_STOP;
                    end
                  end
                  BK_WDATA: begin
                    rem_reg <= rem_reg - 4'h1;
                    if (!bad_ack_reg && rem_reg > 4'h1) begin
                      shift_reg <= wdata_reg;
                    end else begin
                      state_reg <= ST_STOP;
                    end
                  end
                  BK_RDATA: begin
                    rdata_reg <= shift_reg;
                    rem_reg <= rem_reg - 4'h1;
                    if (rem_reg <= 4'h1) begin
                      state_reg <= ST_STOP;
                    end
                  end
                endcase
              end
            end
          end
        end
        ST_STOP: begin
          if (adv) begin
            qtr_reg <= qtr_reg + 2'h1;
            if (qtr_reg == 2'h3) begin
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // open-drain pin drive
  // ------------------------------------------------------------
  // quarters: 0 scl low set sda, 1 scl free, 2 sample, 3 scl low
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      pin_low_reg <= 1'b0;
    end else begin
      pin_low_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
        end
        ST_START: begin
          scl_oe_reg <= (qtr_reg == 2'h0) ? scl_oe_reg : (qtr_reg == 2'h3);
          sda_oe_reg <= qtr_reg[1];
        end
        ST_BIT: begin
          // sda set only in low quarter
          scl_oe_reg <= (qtr_reg == 2'h0) | (qtr_reg == 2'h3);
          if (qtr_reg == 2'h0) begin
            if (kind_reg == BK_RDATA) begin
              // ack all but last read byte
              sda_oe_reg <= (bit_reg == 4'h8) & (rem_reg > 4'h1);
            end else begin
              sda_oe_reg <= (bit_reg != 4'h8) & ~shift_reg[7];
            end
          end
        end
        ST_STOP: begin
          scl_oe_reg <= (qtr_reg == 2'h0);
          sda_oe_reg <= (qtr_reg != 2'h2) & (qtr_reg != 2'h3);
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_avs_waitrequest = waitreq_reg;
  assign o_avs_readdata = readdata_reg;
  assign o_scl_oe = scl_oe_reg;
  assign o_sda_oe = sda_oe_reg;
  assign o_scl_o = pin_low_reg;
  assign o_sda_o = pin_low_reg;

endmodule

// >>> testbench/pot_dev_model.sv
// far-side model: two-wire slave with two 8-bit wiper codes
// assumes scl and sda are resolved wires with pull-ups
`timescale 1ns/1ps
module pot_dev_model #(
  parameter logic [1:0] PIN_SEL = 2'h2
) (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic [7:0] o_wiper_channel_one,
  output logic [7:0] o_wiper_channel_two,
  output logic o_logic_out_first,
  output logic o_logic_out_second
);
  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  logic [7:0] sh;
  logic [7:0] tx;
  int nb;
  int fr;
  logic act;
  logic rd;
  logic chan;
  logic [1:0] soft_shutdown;
  initial begin
    o_wiper_channel_one = 8'h80;
    o_wiper_channel_two = 8'h80;
    o_logic_out_first = 1'b0;
    o_logic_out_second = 1'b0;
    o_sda_oe = 1'b0;
    act = 1'b0;
    chan = 1'b0;
    soft_shutdown = 2'h0;
  end
  always @(negedge i_sda) if (i_scl) begin
    act = 1'b1;
    nb = 0;
    fr = 0;
  end
  always @(posedge i_sda) if (i_scl) act = 1'b0;
  always @(posedge i_scl) if (act) begin
    if (nb < 8) sh = {sh[6:0], i_sda};
    else if (rd && fr > 0 && i_sda) act = 1'b0;
    nb = nb + 1;
  end
  always @(negedge i_scl) begin
    if (act && nb == 8) begin
      if (fr == 0) begin
        act = (sh[7:1] == {5'h0b, PIN_SEL});
        rd = sh[0];
        o_sda_oe = act;
      end else if (!rd) begin
        o_sda_oe = 1'b1;
        if (fr == 1) begin
          chan = sh[7];
          soft_shutdown[sh[7]] = sh[5];
          o_logic_out_second = sh[4];
          o_logic_out_first = sh[3];
          if (sh[6] && sh[7]) o_wiper_channel_two = 8'h80;
          if (sh[6] && !sh[7]) o_wiper_channel_one = 8'h80;
        end else if (chan) o_wiper_channel_two = sh;
        else o_wiper_channel_one = sh;
      end else o_sda_oe = 1'b0;
    end else if (act && nb == 9) begin
      nb = 0;
      fr = fr + 1;
      o_sda_oe = 1'b0;
      tx = chan ? o_wiper_channel_two : o_wiper_channel_one;
    end
    if (act && rd && fr > 0 && nb < 8) o_sda_oe = !tx[7 - nb];
  end
endmodule

// >>> testbench/pot_host_checker.sv
// port assertions for the potentiometer host controller
// assumes one clock domain; bound onto pot_host below
`timescale 1ns/1ps
module pot_host_checker (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_scl_i,
  input wire logic o_scl_o,
  input wire logic o_scl_oe,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe
);
  // ----------------------------------------
  // bus handshake and wire framing
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wait_answer_a: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("access not answered in one cycle");
  wait_cause_a: assert property (!o_avs_waitrequest |->
    $past(i_avs_read || i_avs_write)) else $error("answer without access");
  rst_idle_a: assert property ($fell(i_srst) |-> o_avs_waitrequest &&
    !o_scl_oe && !o_sda_oe) else $error("bus not idle after reset");
  // open drain: only ever pull low
  od_low_a: assert property (!o_scl_o && !o_sda_o)
    else $error("pin driven high");
  start_clk_a: assert property ($rose(o_sda_oe) && !o_scl_oe |->
    ##[1:1000] o_scl_oe) else $error("start without clocking");
  stop_idle_a: assert property ($fell(o_sda_oe) && !o_scl_oe |=>
    !o_scl_oe [*8]) else $error("clock after stop");
  scl_high_a: assert property ($fell(o_scl_oe) |=>
    (!o_scl_oe && $stable(o_sda_oe)) [*8]) else $error("sda moved high");
  scl_low_a: assert property ($rose(o_scl_oe) |=> o_scl_oe [*8])
    else $error("scl low too short");
endmodule
bind pot_host pot_host_checker chk_u (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_scl_i(i_scl_i), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
  .i_sda_i(i_sda_i), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));

// >>> testbench/pot_host_tb.sv
// self-checking bench for the potentiometer host controller
// assumes the device model pot_dev_model on scl and sda
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pot_host_tb;
  // ----------------------------------------
  // clock, wires and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [2:0] adr = 3'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq, scl_oe, sda_oe, dev_oe, o1, o2;
  logic [7:0] w1, w2;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || dev_oe);
  always #4 clk = ~clk;
  pot_host dut_u (.i_sys_clk(clk), .i_srst(srst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_scl_i(scl), .o_scl_o(),
    .o_scl_oe(scl_oe), .i_sda_i(sda), .o_sda_o(), .o_sda_oe(sda_oe));
  pot_dev_model #(.PIN_SEL(2'h2)) dev_u (.i_scl(scl), .i_sda(sda),
    .o_sda_oe(dev_oe), .o_wiper_channel_one(w1),
    .o_wiper_channel_two(w2), .o_logic_out_first(o1),
    .o_logic_out_second(o2));
  task automatic summarize;
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // three transfers take near 99k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 110000) begin
      failures++;
      summarize();
    end
  end
  task automatic acc(input logic w, input logic [2:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    `CHK(q, {24'h0, e})
  endtask
  task automatic idle;
    logic [31:0] q;
    q = 32'h1;
    while (q[0] !== 1'b0) acc(1'b0, 3'h5, 32'h0, q);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rchk(3'h3, 8'h80);
    rchk(3'h2, 8'h00);
    rchk(3'h5, 8'h00);
    rchk(3'h6, 8'h00);
    // write channel two, low instruction bits dropped
    wreg(3'h1, 8'h02);
    wreg(3'h2, 8'h97);
    rchk(3'h2, 8'h90);
    wreg(3'h3, 8'h3c);
    wreg(3'h0, 8'h10);
    idle();
    rchk(3'h5, 8'h02);
    `CHK(w2, 8'h3c)
    `CHK(w1, 8'h80)
    `CHK({o2, o1}, 2'b10)
    wreg(3'h5, 8'h02);
    // channel one by instruction, repeated start, read back
    wreg(3'h2, 8'h08);
    wreg(3'h0, 8'h12);
    idle();
    rchk(3'h4, 8'h80);
    `CHK({o2, o1}, 2'b01)
    `CHK(w2, 8'h3c)
    wreg(3'h5, 8'h02);
    // plain read to wrong select bits: refused at the address byte
    wreg(3'h1, 8'h01);
    wreg(3'h0, 8'h11);
    idle();
    rchk(3'h5, 8'h06);
    rchk(3'h4, 8'h80);
    `CHK(w2, 8'h3c)
    summarize();
  end
endmodule
